/* File: dv/acg_clock_gen_props.sv */
// Purpose: Port-level checks of the clock generator.
// Assumes: Reference pins toggle no faster than every two system clocks.
// Notes: Frame rate figures are measured by the bench; here only order and timing.
`timescale 1ns/1ps
module acg_clock_gen_props (
  // System
  input wire clk,
  input wire sys_rst,
  // Bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Clock outputs
  input wire master_tick,
  input wire fsref_tick,
  input wire playback_frame,
  input wire record_frame,
  input wire wclk_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_FS_ON_MT: assert property (fsref_tick |-> $past(master_tick))
    else $error("reference tick without master tick");
  AST_FS_SPACED: assert property (fsref_tick |=> !fsref_tick [*8])
    else $error("reference ticks too close");
  AST_MT_SPACED: assert property (master_tick |=> !master_tick [*3])
    else $error("master tick runt");
  AST_PB_ON_MT: assert property (playback_frame |-> $past(master_tick))
    else $error("playback frame off master tick");
  AST_RC_ON_MT: assert property (record_frame |-> $past(master_tick))
    else $error("record frame off master tick");
  AST_WCLK_NEXT: assert property (playback_frame |=> wclk_out && !playback_frame)
    else $error("word clock missed playback frame");
  AST_WCLK_CAUSE: assert property ($rose(wclk_out) |-> $past(playback_frame))
    else $error("word clock without playback frame");
  AST_WR_ANS: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
    else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_RD_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  COV_FS: cover property (fsref_tick);
  COV_RC: cover property (record_frame);
  COV_ERR: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind acg_clock_gen acg_clock_gen_props u_props (.clk(clk), .sys_rst(sys_rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .master_tick(master_tick), .fsref_tick(fsref_tick), .playback_frame(playback_frame),
  .record_frame(record_frame), .wclk_out(wclk_out));

/* File: dv/acg_clock_gen_tb_top.sv */
// Purpose: Self-checking bench for the audio clock and rate generator.
// Assumes: Reference pins run free at fixed multiples of the system clock.
// Notes: Rates are judged by pulse gaps after three pulses of settling.
`timescale 1ns/1ps
module acg_clock_gen_tb_top;
  reg clk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg [11:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata;
  reg [3:0] s_axi_wstrb;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire mclk_pin, bclk_pin, pin2, mt, fs, pb, rc, wclk, pin1, pin1_oe;
  integer mismatches, checks_done, i;
  reg [15:0] ck_fs, fs_gap, mt_pb, pb_gap, mt_rc, rc_gap, ck_p1, p1_gap;
  reg p1_q, rf_q, fm, p1_err;
  wire [3:0] ev = {pin1 !== p1_q, rc, pb, fs};
  // Entries: source select, synth control, Q code, reference gap in clocks
  // integer K only, J of 4 and 8, R of one
  localparam [287:0] FST = {48'h10_0801_00_0600, 48'h00_0401_00_0800, 48'h00_0100_02_0800,
    48'h80_0100_00_0500, 48'h40_0100_00_0600, 48'h00_0100_00_0400};
  localparam [127:0] PBV = {32'h81800, 32'h85000, 32'h800, 32'h0};
  localparam [63:0] PBE = {16'd320, 16'd768, 16'd384, 16'd256};
  localparam [191:0] CKT = {32'h00c00230, 16'd20, 32'h00800230, 16'd20, 32'h008007f0, 16'd136,
    32'h00800490, 16'd8};
  acg_clock_gen DUT (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .mclk_pin(mclk_pin), .bclk_pin(bclk_pin),
    .general_pin_two(pin2), .master_tick(mt), .fsref_tick(fs), .playback_frame(pb),
    .record_frame(rc), .wclk_out(wclk), .general_pin_one_out(pin1), .general_pin_one_oe(pin1_oe));
  acg_ref_src SRC (.run(1'b1), .mclk_pin(mclk_pin), .bclk_pin(bclk_pin), .general_pin_two(pin2));
  always #20 clk = ~clk;
  always @(posedge clk) begin
    ck_fs <= fs ? 16'h0001 : ck_fs + 16'h0001;
    if (fs) fs_gap <= ck_fs;
    mt_pb <= pb ? 16'h0000 : mt_pb + mt;
    if (pb) pb_gap <= mt_pb;
    mt_rc <= rc ? 16'h0000 : mt_rc + mt;
    if (rc) rc_gap <= mt_rc;
    ck_p1 <= ev[3] ? 16'h0001 : ck_p1 + 16'h0001;
    if (ev[3]) p1_gap <= ck_p1;
    p1_q <= pin1;
    rf_q <= rc;
    if (fm && pin1 !== rf_q) p1_err <= 1'b1;
  end
  task close_out;
    begin
      if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] exp, input [31:0] val);
    begin
      checks_done = checks_done + 1;
      if (val !== exp) begin
        mismatches = mismatches + 1;
        $display("BAD %0s expected %h seen %h", nm, exp, val);
      end
    end
  endtask
  task tmo;
    begin
      chk("wait bound", 32'h1, 32'h0);
      close_out;
    end
  endtask
  task wr(input [11:0] a, input [31:0] d, input [1:0] er);
    integer n;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 100 && !(s_axi_bvalid && s_axi_bready); n = n + 1) begin
        @(posedge clk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      if (!(s_axi_bvalid && s_axi_bready)) tmo;
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
      s_axi_bready <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd(input [11:0] a, input [31:0] exp, input [31:0] msk, input [1:0] er);
    integer n;
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 100 && !(s_axi_rvalid && s_axi_rready); n = n + 1) begin
        @(posedge clk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      if (!(s_axi_rvalid && s_axi_rready)) tmo;
      chk("rdata", exp, s_axi_rdata & msk);
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
      s_axi_rready <= 1'b0;
      @(posedge clk);
    end
  endtask
  // Three events of the chosen kind, then one edge so the gap registers settle
  task settle(input integer s);
    integer n, k;
    begin
      k = 0;
      for (n = 0; n < 20000 && k < 3; n = n + 1) begin
        @(posedge clk);
        if (ev[s]) k = k + 1;
      end
      if (k < 3) tmo;
      @(posedge clk);
    end
  endtask
  initial begin
    mismatches = 0;
    checks_done = 0;
    {clk, fm, p1_err, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h00;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 58'h0;
    s_axi_wstrb = 4'hf;
    sys_rst = 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk("pin one enable", 32'h0, {31'h0, pin1_oe});
    rd(12'h198, 32'h0, 32'hffffffff, 2'h0);
    rd(12'h00c, 32'h100, 32'hffffffff, 2'h0);
    rd(12'h010, 32'h00400000, 32'hffffffff, 2'h0);
    rd(12'h000, 32'h0, 32'hffffffff, 2'h2);
    wr(12'h3fc, 32'h1, 2'h2);
    wr(12'h014, 32'hffffffff, 2'h0);
    wr(12'h198, 32'h5a, 2'h0);
    rd(12'h198, 32'h5a, 32'hffffffff, 2'h0);
    wr(12'h010, 32'h00a10000, 2'h0);
    fm <= 1'b1;
    settle(2);
    chk("record gap", 32'd512, {16'h0, rc_gap});
    for (i = 0; i < 4; i = i + 1) begin
      wr(12'h010, 32'h00a10000 | PBV[32*i +: 32], 2'h0);
      settle(1);
      chk("playback gap", {16'h0, PBE[16*i +: 16]}, {16'h0, pb_gap});
    end
    for (i = 0; i < 6; i = i + 1) begin
      wr(12'h198, {24'h0, FST[48*i+40 +: 8]}, 2'h0);
      wr(12'h00c, {16'h0, FST[48*i+24 +: 16]}, 2'h0);
      wr(12'h010, 32'h00a10000 | FST[48*i+16 +: 8], 2'h0);
      settle(0);
      chk("reference gap", {16'h0, FST[48*i +: 16]}, {16'h0, fs_gap});
      rd(12'h014, {30'h0, FST[48*i+24], 1'b1}, 32'h3, 2'h0);
    end
    chk("pin one frame", 32'h0, {31'h0, p1_err});
    fm <= 1'b0;
    wr(12'h198, 32'h0, 2'h0);
    wr(12'h00c, 32'h401, 2'h0);
    for (i = 0; i < 4; i = i + 1) begin
      wr(12'h010, CKT[48*i+16 +: 32], 2'h0);
      settle(3);
      chk("pin one half period", {16'h0, CKT[48*i +: 16]}, {16'h0, p1_gap});
      chk("pin one enable", 32'h1, {31'h0, pin1_oe});
    end
    rd(12'h014, 32'h2, 32'h6, 2'h0);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(12'h010, 32'h00400000, 32'hffffffff, 2'h0);
    close_out;
  end
endmodule

/* File: dv/acg_ref_src.sv */
// Purpose: Reference clock source facing the clock generator pins.
// Assumes: Master and bit clock half periods are whole multiples of the 40 ns system clock; pin two's 100 ns is two and a half.
// Notes: A 7 ns phase offset keeps pin edges out of the system clock time step.
`timescale 1ns/1ps
module acg_ref_src #(
  parameter integer MCLK_HALF = 80,
  parameter integer BCLK_HALF = 120,
  parameter integer PIN2_HALF = 100
) (
  // Control
  input wire run,
  // Reference pins
  output reg mclk_pin,
  output reg bclk_pin,
  output reg general_pin_two
);
  initial begin
    mclk_pin = 1'b0;
    #7;
    forever begin
      #(MCLK_HALF);
      mclk_pin = run ? ~mclk_pin : 1'b0;
    end
  end
  initial begin
    bclk_pin = 1'b0;
    #7;
    forever begin
      #(BCLK_HALF);
      bclk_pin = run ? ~bclk_pin : 1'b0;
    end
  end
  initial begin
    general_pin_two = 1'b0;
    #7;
    forever begin
      #(PIN2_HALF);
      general_pin_two = run ? ~general_pin_two : 1'b0;
    end
  end
endmodule

/* File: rtl/acg_clock_gen.v */
// Purpose: Audio clock generation, converter rate division and clock output.
// Assumes: Reference pins are sampled by the 25 MHz system clock; all rates are enables.
// Notes: Registers over AXI4-Lite; unmapped addresses answer SLVERR.
// Function
// R1: Produce a master tick at 256 times the reference rate.
// R2: Converter rates are reference over ratio, or twice that, ratio 1 to 6.
// R3: One reference rate; record and playback dividers set separately.
// R4: When rates differ, word clock marks playback, pin one marks record frames.
// R5: Without synthesiser, reference is divider input over 128 times Q (2..17).
// R6: Source select bits 7:6 pick master, bit clock or pin two.
// R7: Software avoids odd Q with half ratios and keeps reference 39 to 53 kHz.
// R8: With synthesiser, reference is input times K times R over 2048 times P.
// R9: K is integer J (1..63) plus fraction D/10000, D 0..9999.
// R10: Source select bits 5:4 pick synthesiser input, master or bit clock.
// R11: Software keeps integer-K synthesiser settings within their ranges.
// R12: Software keeps fractional-K synthesiser settings within their ranges, R one.
// R13: Synthesiser output to pin one is input times 2KR over M N P.
// R14: Divider output to pin one is input times 2 over M N.
// R15: Synthesiser output on pin one keeps working while codec is powered down.
// R16: Master clock input path accepts its full reference range.
// R17: Software supplies a reference clock whenever a converter runs.
// R18: Main word clock runs at the higher converter rate; the code drives it from the playback frame alone.
// R19: Reprogramming never makes runt pulses on master tick or pin one clock.
// R20: Fractional multiplication is exact in the long-run average.
`timescale 1ns/1ps
`include "acg_defines.vh"
module acg_clock_gen (
  // System
  input wire clk,
  input wire sys_rst,
  // AXI4-Lite write address
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // Reference clock pins
  input wire mclk_pin,
  input wire bclk_pin,
  input wire general_pin_two,
  // Clock and frame outputs
  output wire master_tick,
  output wire fsref_tick,
  output wire playback_frame,
  output wire record_frame,
  output wire wclk_out,
  output wire general_pin_one_out,
  output wire general_pin_one_oe
);

  function [10:0] fs_period;
    input [3:0] code;
    input dbl;
    reg [3:0] c;
    reg [10:0] n2;
    begin
      c = (code > `ACG_RATIO_CODE_MAX) ? `ACG_RATIO_CODE_MAX : code;
      n2 = {7'h00, c} + 11'h002;
      fs_period = dbl ? n2 * `ACG_FS_DOUBLE : n2 * `ACG_FS_SINGLE;
    end
  endfunction

  // Register file
  reg [7:0] clock_source_select_ff;
  reg [31:0] synth_ctrl_ff;
  reg [31:0] divider_ctrl_ff;

  // AXI state
  reg aw_held_ff;
  reg w_held_ff;
  reg [9:0] aw_idx_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg rvalid_ff;
  reg [1:0] rresp_ff;
  reg [31:0] rdata_ff;

  // Clock state
  reg [7:0] fs_cnt_ff;
  reg [7:0] fs_total_ff;
  reg fsref_ff;
  reg [10:0] pb_cnt_ff;
  reg [10:0] rc_cnt_ff;
  reg pb_frame_ff;
  reg rc_frame_ff;
  reg wclk_ff;
  reg g1_frame_ff;
  reg clkout_ff;

  // Write channel: address and data may arrive in either order
  assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_held_ff & ~bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  wire do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
  wire wr_src = (aw_idx_ff == `ACG_IDX_CLK_SRC);
  wire wr_pll = (aw_idx_ff == `ACG_IDX_PLL);
  wire wr_div = (aw_idx_ff == `ACG_IDX_DIV);
  wire wr_map = wr_src | wr_pll | wr_div | (aw_idx_ff == `ACG_IDX_STATUS);

  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_idx_ff <= 10'h000;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `ACG_RESP_OKAY;
      clock_source_select_ff <= `ACG_CLK_SRC_RST;
      synth_ctrl_ff <= `ACG_PLL_RST;
      divider_ctrl_ff <= `ACG_DIV_RST;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_ff <= 1'b1;
        aw_idx_ff <= s_axi_awaddr[11:2];
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_map ? `ACG_RESP_OKAY : `ACG_RESP_SLVERR;
        // R6 R10 source select storage
        if (wr_src && wstrb_ff[0]) begin
          clock_source_select_ff <= wdata_ff[7:0];
        end
        if (wr_pll) begin
          synth_ctrl_ff <= merge(synth_ctrl_ff, wdata_ff, wstrb_ff);
        end
        if (wr_div) begin
          divider_ctrl_ff <= merge(divider_ctrl_ff, wdata_ff, wstrb_ff);
        end
      end else if (bvalid_ff & s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Field decode
  wire pll_en = synth_ctrl_ff[`ACG_F_PLL_EN];
  wire [3:0] p_val = {1'b0, synth_ctrl_ff[`ACG_F_P]} + 4'h1;
  wire [4:0] r_val = {1'b0, synth_ctrl_ff[`ACG_F_R]} + 5'h01;
  wire [5:0] j_raw = synth_ctrl_ff[`ACG_F_J];
  wire [13:0] d_raw = synth_ctrl_ff[`ACG_F_D];
  wire [3:0] q_code = divider_ctrl_ff[`ACG_F_Q];
  wire [3:0] m_val = 4'h1 << divider_ctrl_ff[`ACG_F_M];
  wire [4:0] n_val = {1'b0, divider_ctrl_ff[`ACG_F_N]} + 5'h02;
  wire clock_output_source_select = divider_ctrl_ff[`ACG_F_CLKMUX];
  wire codec_pwdn = divider_ctrl_ff[`ACG_F_PWDN];

  // R9 J of zero is treated as one, D above 9999 is held at 9999
  wire [5:0] j_val = (j_raw == 6'h00) ? 6'h01 : j_raw;
  wire [13:0] d_val = (d_raw > `ACG_D_MAX) ? `ACG_D_MAX : d_raw;
  wire [19:0] k_scaled = {14'h0000, j_val} * `ACG_D_SCALE + {6'h00, d_val};
  wire [24:0] kr_scaled = k_scaled * r_val;

  // R5 Q code 0..15 stands for Q 2..17
  wire [27:0] q_mod = {24'h000000, q_code} + 28'h0000002;

  // Synchronised reference pins
  wire mclk_rise;
  wire bclk_rise;
  wire g2_rise;

  // R16 master clock sampled as a plain edge stream
  acg_edge_sync u_sync_mclk (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in(mclk_pin),
    .rise_pulse(mclk_rise)
  );

  acg_edge_sync u_sync_bclk (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in(bclk_pin),
    .rise_pulse(bclk_rise)
  );

  acg_edge_sync u_sync_g2 (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in(general_pin_two),
    .rise_pulse(g2_rise)
  );

  // R6 divider input select
  reg divider_source_clock;
  always @* begin
    case (clock_source_select_ff[`ACG_F_DIVSRC])
      `ACG_SRC_BCLK: divider_source_clock = bclk_rise;
      `ACG_SRC_GENERAL_PIN_TWO: divider_source_clock = g2_rise;
      default: divider_source_clock = mclk_rise;
    endcase
  end

  // R10 synthesiser input select, master clock unless bit clock chosen
  wire synth_source_clock = (clock_source_select_ff[`ACG_F_PLLSRC] == `ACG_SRC_BCLK) ?
                            bclk_rise : mclk_rise;

  // R5 plain divider: master rate is 2 x input / Q, i.e. 256 x input / (128 Q)
  wire div_mstr;
  acg_frac_acc #(.W(28)) u_div_mstr (
    .clk(clk),
    .sys_rst(sys_rst),
    .clr(pll_en | codec_pwdn),
    .step_en(divider_source_clock),
    .inc(`ACG_DIV_MSTR_INC),
    .modulus(q_mod),
    .tick(div_mstr)
  );

  // R8 R20 synthesiser: master rate is input x K x R / (8 P), remainder carried
  wire pll_mstr;
  acg_frac_acc #(.W(28)) u_pll_mstr (
    .clk(clk),
    .sys_rst(sys_rst),
    .clr(~pll_en | codec_pwdn),
    .step_en(synth_source_clock),
    .inc({3'h0, kr_scaled}),
    .modulus({4'h0, p_val * `ACG_PLL_MSTR_MOD}),
    .tick(pll_mstr)
  );

  // R1 master tick from whichever path is enabled
  wire mstr_raw = pll_en ? pll_mstr : div_mstr;
  // A source or path switch can bring two ticks close; the late one is dropped
  reg [1:0] mt_gap_ff;
  // R19 tick hold-off
  wire mstr = mstr_raw & (mt_gap_ff == `ACG_MT_HOLDOFF);

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mt_gap_ff <= `ACG_MT_HOLDOFF;
    end else if (mstr) begin
      mt_gap_ff <= 2'h0;
    end else if (mt_gap_ff != `ACG_MT_HOLDOFF) begin
      mt_gap_ff <= mt_gap_ff + 2'h1;
    end
  end

  // R3 single reference rate derived from the one master tick
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fs_cnt_ff <= 8'h00;
      fsref_ff <= 1'b0;
      fs_total_ff <= 8'h00;
    end else begin
      fsref_ff <= 1'b0;
      if (codec_pwdn) begin
        fs_cnt_ff <= 8'h00;
      end else if (mstr) begin
        fs_cnt_ff <= fs_cnt_ff + 8'h01;
        if (fs_cnt_ff == `ACG_MSTR_PER_FS) begin
          fsref_ff <= 1'b1;
          fs_total_ff <= fs_total_ff + 8'h01;
        end
      end
    end
  end

  // R2 R3 independent playback and record dividers
  wire [10:0] pb_period = fs_period(divider_ctrl_ff[`ACG_F_PB_RATIO],
                                    divider_ctrl_ff[`ACG_F_PB_DBL]);
  wire [10:0] rc_period = fs_period(divider_ctrl_ff[`ACG_F_RC_RATIO],
                                    divider_ctrl_ff[`ACG_F_RC_DBL]);
  wire rates_differ = (pb_period != rc_period);

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pb_cnt_ff <= 11'h000;
      rc_cnt_ff <= 11'h000;
      pb_frame_ff <= 1'b0;
      rc_frame_ff <= 1'b0;
    end else begin
      pb_frame_ff <= 1'b0;
      rc_frame_ff <= 1'b0;
      if (codec_pwdn) begin
        pb_cnt_ff <= 11'h000;
        rc_cnt_ff <= 11'h000;
      end else if (mstr) begin
        // R19 compare with >= so a shortened period wraps at once, no runt
        if (pb_cnt_ff >= pb_period - 11'h001) begin
          pb_cnt_ff <= 11'h000;
          pb_frame_ff <= 1'b1;
        end else begin
          pb_cnt_ff <= pb_cnt_ff + 11'h001;
        end
        if (rc_cnt_ff >= rc_period - 11'h001) begin
          rc_cnt_ff <= 11'h000;
          rc_frame_ff <= 1'b1;
        end else begin
          rc_cnt_ff <= rc_cnt_ff + 11'h001;
        end
      end
    end
  end

  // R4 R18 word clocks: with equal rates one frame pulse serves both streams
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wclk_ff <= 1'b0;
      g1_frame_ff <= 1'b0;
    end else begin
      wclk_ff <= pb_frame_ff;
      g1_frame_ff <= rates_differ & rc_frame_ff;
    end
  end

  // Clock output divider, toggled so pin frequency is half the tick rate
  wire [7:0] mn_val = m_val * n_val;
  wire [27:0] co_inc = clock_output_source_select ? `ACG_TOGGLE_INC : {1'b0, kr_scaled, 2'b00};
  wire [27:0] co_mod = clock_output_source_select ? {20'h00000, mn_val} :
                       mn_val * p_val * `ACG_MN_P_SCALE;
  // R13 R14 step source follows the selected formula
  wire co_step = clock_output_source_select ? divider_source_clock : (pll_en & synth_source_clock);
  wire co_tick;
  // R15 clock output runs regardless of codec power state
  acg_frac_acc #(.W(28)) u_clk_out (
    .clk(clk),
    .sys_rst(sys_rst),
    .clr(~clock_output_source_select & ~pll_en),
    .step_en(co_step),
    .inc(co_inc),
    .modulus(co_mod),
    .tick(co_tick)
  );

  // R19 only a flop toggles the output, every level lasts whole ticks
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clkout_ff <= 1'b0;
    end else if (co_tick) begin
      clkout_ff <= ~clkout_ff;
    end
  end

  // Read channel: one cycle from acceptance to rvalid
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= `ACG_RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end else if (s_axi_arvalid & ~rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= `ACG_RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
      case (s_axi_araddr[11:2])
        `ACG_IDX_CLK_SRC: rdata_ff <= {24'h000000, clock_source_select_ff};
        `ACG_IDX_PLL: rdata_ff <= synth_ctrl_ff;
        `ACG_IDX_DIV: rdata_ff <= divider_ctrl_ff;
        `ACG_IDX_STATUS: begin
          rdata_ff[`ACG_F_ST_DIFF] <= rates_differ;
          rdata_ff[`ACG_F_ST_PLL] <= pll_en;
          rdata_ff[`ACG_F_ST_RUN] <= ~codec_pwdn;
          rdata_ff[`ACG_F_ST_FSCNT] <= fs_total_ff;
        end
        default: rresp_ff <= `ACG_RESP_SLVERR;
      endcase
    end else if (rvalid_ff & s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Outputs
  assign master_tick = mstr;
  assign fsref_tick = fsref_ff;
  assign playback_frame = pb_frame_ff;
  assign record_frame = rc_frame_ff;
  assign wclk_out = wclk_ff;
  // R4 pin one carries either the record frame clock or the divided clock
  assign general_pin_one_out = divider_ctrl_ff[`ACG_F_G1_FRAME] ? g1_frame_ff : clkout_ff;
  assign general_pin_one_oe = divider_ctrl_ff[`ACG_F_G1_EN];
endmodule

/* File: rtl/acg_defines.vh */
// Purpose: Named constants for the audio clock and rate generator.
// Assumes: Included by the acg_clock_gen design file only.
// Notes: Register indices are word indices; the byte address is four times the index.
`ifndef ACG_DEFINES_VH
`define ACG_DEFINES_VH

// Register word indices
`define ACG_IDX_CLK_SRC 10'h066
`define ACG_IDX_PLL 10'h003
`define ACG_IDX_DIV 10'h004
`define ACG_IDX_STATUS 10'h005

// Reset values
`define ACG_CLK_SRC_RST 8'h00
`define ACG_PLL_RST 32'h0000_0100
`define ACG_DIV_RST 32'h0040_0000

// clock_source_select fields
`define ACG_F_DIVSRC 7:6
`define ACG_F_PLLSRC 5:4
`define ACG_SRC_MCLK 2'h0
`define ACG_SRC_BCLK 2'h1
`define ACG_SRC_GENERAL_PIN_TWO 2'h2

// Synthesiser control fields
`define ACG_F_PLL_EN 0
`define ACG_F_P 3:1
`define ACG_F_R 7:4
`define ACG_F_J 13:8
`define ACG_F_D 27:14

// Divider control fields
`define ACG_F_Q 3:0
`define ACG_F_M 5:4
`define ACG_F_N 9:6
`define ACG_F_CLKMUX 10
`define ACG_F_PB_RATIO 14:11
`define ACG_F_RC_RATIO 18:15
`define ACG_F_PB_DBL 19
`define ACG_F_RC_DBL 20
`define ACG_F_G1_FRAME 21
`define ACG_F_PWDN 22
`define ACG_F_G1_EN 23

// Status fields
`define ACG_F_ST_DIFF 0
`define ACG_F_ST_PLL 1
`define ACG_F_ST_RUN 2
`define ACG_F_ST_FSCNT 15:8

// Arithmetic constants
`define ACG_D_SCALE 20'd10000
`define ACG_D_MAX 14'd9999
`define ACG_Q_CODE_MAX 4'hf
`define ACG_RATIO_CODE_MAX 4'ha
`define ACG_PLL_MSTR_MOD 24'd80000
`define ACG_MN_P_SCALE 28'd10000
`define ACG_DIV_MSTR_INC 28'h0000002
`define ACG_TOGGLE_INC 28'h0000004
`define ACG_MSTR_PER_FS 8'hff
`define ACG_FS_SINGLE 11'h080
`define ACG_FS_DOUBLE 11'h040
`define ACG_MT_HOLDOFF 2'h3

// AXI responses
`define ACG_RESP_OKAY 2'h0
`define ACG_RESP_SLVERR 2'h2

`endif

/* File: rtl/acg_edge_sync.v */
// Purpose: Brings a pin clock into the system clock domain as a rising-edge pulse.
// Assumes: Pin toggles slower than half the system clock.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module acg_edge_sync (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Pin and result
  input wire pin_in,
  output wire rise_pulse
);
  reg meta_ff;
  reg sync_ff;
  reg last_ff;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign rise_pulse = sync_ff & ~last_ff;
endmodule

/* File: rtl/acg_frac_acc.v */
// Purpose: Fractional rate divider: one tick per modulus/inc steps on average.
// Assumes: inc below modulus; otherwise the tick rate saturates at one per step.
// Notes: Remainder is carried, so the long-run rate is exact.
`timescale 1ns/1ps
module acg_frac_acc #(
  parameter W = 28
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Control
  input wire clr,
  input wire step_en,
  input wire [W-1:0] inc,
  input wire [W-1:0] modulus,
  // Result
  output wire tick
);
  reg [W-1:0] acc_ff;
  reg tick_ff;
  reg [W-1:0] nxt_acc;
  reg nxt_tick;
  wire [W:0] sum = {1'b0, acc_ff} + {1'b0, inc};

  always @* begin
    nxt_acc = acc_ff;
    nxt_tick = 1'b0;
    if (clr) begin
      nxt_acc = {W{1'b0}};
    end else if (step_en) begin
      if (sum >= {modulus, 1'b0}) begin
        // Far ahead after a setting change or saturation: restart, never run away
        nxt_acc = {W{1'b0}};
        nxt_tick = 1'b1;
      end else if (sum >= {1'b0, modulus}) begin
        nxt_acc = sum[W-1:0] - modulus;
        nxt_tick = 1'b1;
      end else begin
        nxt_acc = sum[W-1:0];
      end
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_ff <= {W{1'b0}};
      tick_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;
endmodule
